// ### rtl/sfr_consts.vh
// Constants for the refresh and power-fail controller.
// Assumes a 40 MHz CLK; all counts are in CLK cycles.
`ifndef SFR_CONSTS_VH
`define SFR_CONSTS_VH
`define SFR_CLK_MHZ           32'h28
`define SFR_ROWS              32'h200
`define SFR_REFRESH_PERIOD_MS 32'h20
`define SFR_REFRESH_CYC       ((`SFR_REFRESH_PERIOD_MS * 32'h3e8 * `SFR_CLK_MHZ) / `SFR_ROWS)
`define SFR_RCF_MAX_US        32'h5
`define SFR_RCF_MAX_CYC       (`SFR_RCF_MAX_US * `SFR_CLK_MHZ)
`define SFR_OSC_KHZ           32'h32
`define SFR_OSC_CYC           ((`SFR_CLK_MHZ * 32'h3e8) / `SFR_OSC_KHZ)
`define SFR_OSC_LOW_CYC       16'h0008
`define SFR_CBR_SETUP_CYC     16'h0002
`define SFR_CBR_LOW_CYC       16'h0008
`define SFR_CBR_PRE_CYC       16'h0004
`define SFR_GAP_MARGIN_CYC    16'h0014
`define SFR_RESUME_DLY_US     32'h64
`define SFR_RESUME_DLY_CYC    (`SFR_RESUME_DLY_US * `SFR_CLK_MHZ)
`define SFR_NMI_PULSE_CYC     4'h4
`endif

// ### rtl/sfr_sync.v
// Two-stage synchroniser for one level input.
// Assumes the input is asynchronous to CLK.
`timescale 1ns/1ps
`default_nettype none
module sfr_sync (
	// Clock and reset
	input  wire clk,
	input  wire rst_b,
	// Level
	input  wire d,
	output reg  q
);
	reg meta_ff;
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			meta_ff <= 1'b0;
			q       <= 1'b0;
		end else begin
			meta_ff <= d;
			q       <= meta_ff;
		end
	end
endmodule // sfr_sync
`default_nettype wire

// ### rtl/sfr_timer.v
// Down-counting interval timer with a load and a done flag.
// Assumes load is a one-cycle request from the same clock.
`timescale 1ns/1ps
`default_nettype none
module sfr_timer #(
	parameter WIDTH = 16
) (
	// Clock and reset
	input  wire             clk,
	input  wire             rst_b,
	// Control
	input  wire             load,
	input  wire [WIDTH-1:0] value,
	// Status
	output wire             done
);
	reg [WIDTH-1:0] cnt_ff;
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_ff <= {WIDTH{1'b0}};
		end else if (load) begin
			cnt_ff <= value;
		end else if (cnt_ff != {WIDTH{1'b0}}) begin
			cnt_ff <= cnt_ff - {{(WIDTH-1){1'b0}}, 1'b1};
		end
	end
	assign done = (cnt_ff == {WIDTH{1'b0}}) && !load;
endmodule // sfr_timer
`default_nettype wire

// ### rtl/sfr_ctrl.v
// Refresh scheduler and power-fail controller for a pulse-refreshed 1M x 1 memory.
// Assumes a 40 MHz CLK; POWER_FAIL and ACCESS_REQ come from outside and are synchronised.
//
// Functional notes
// [R1] Issue 512 column-first refreshes per 32 ms, one about every 62 us; the gap timer brings one every 183 cycles (about 4.6 us) instead.
// [R2] Access bursts longer than the self-refresh limit are covered by column-first refresh.
// [R3] Memory supplies the row address during column-first refresh; no address driven.
// [R4] Memory advances one shared refresh counter in both refresh modes.
// [R5] Memory counter steps once per nineteen pulses in self-refresh, once per column-first cycle.
// [R6] No extra refresh burst needed before self-refresh when column-first refresh is used.
// [R7] Keep self-refresh cycle interval within the temperature dependent maximum.
// [R8] Last self-refresh pulse to first column-first cycle within the maximum interval.
// [R9] Last column-first cycle to first self-refresh pulse within the maximum interval.
// [R10] Across short bursts, self-refresh pulse gap stays within the maximum interval.
// [R11] Row-only refresh does not advance the counter; other methods need 512-cycle bursts.
// [R12] Use column-first refresh in normal operation whenever self-refresh is used.
// [R13] On power failure drive refresh request low and raise processor interrupt.
// [R14] Power-fail indication drives separate interrupt and timing-init lines.
// [R15] During power fail the row strobe comes from the self-refresh oscillator.
// [R16] Self-refresh oscillator runs at 50 kHz for a 50 degree system.
// [R17] On power return, after delay, second interrupt; then release request, resume timing.
// [R18] Memory has no error checking; protection lies outside.
// [R19] Self-refresh: request low then slow row-strobe pulses, which must continue.
// [R20] Memory divides the row strobe by nineteen internally in self-refresh.
// [R21] Memory waits about 2.5 ms after request low before low-power self-refresh.
// [R22] Column-first refresh: column strobe low before row strobe, write enable high.
`timescale 1ns/1ps
`default_nettype none
`include "sfr_consts.vh"
module sfr_ctrl #(
	parameter REFRESH_CYC    = `SFR_REFRESH_CYC,
	parameter RCF_MAX_CYC    = `SFR_RCF_MAX_CYC,
	parameter OSC_CYC        = `SFR_OSC_CYC,
	parameter RESUME_DLY_CYC = `SFR_RESUME_DLY_CYC,
	parameter TW             = 16
) (
	// Clock and reset
	input  wire CLK,
	input  wire RST_B,
	// Power detector
	input  wire POWER_FAIL,
	// Access timing generator
	input  wire ACCESS_REQ,
	input  wire ACCESS_RAS_N,
	input  wire ACCESS_CAS_N,
	input  wire ACCESS_WE_N,
	output reg  ACCESS_GRANT,
	// Memory strobes
	output reg  RAS_N,
	output reg  CAS_N,
	output reg  WE_N,
	output reg  SELF_REFRESH_REQUEST_N,
	// Processor and timing generator
	output reg  NMI,
	output reg  TIMING_INIT,
	output reg  CPU_RESET_NMI
);
	// ****************************************
	// Input synchronisers
	// ****************************************
	wire pf_s;
	wire acc_s;
	sfr_sync u_pf_sync (
		.clk   (CLK),
		.rst_b (RST_B),
		.d     (POWER_FAIL),
		.q     (pf_s)
	);
	sfr_sync u_acc_sync (
		.clk   (CLK),
		.rst_b (RST_B),
		.d     (ACCESS_REQ),
		.q     (acc_s)
	);

	// ****************************************
	// States
	// ****************************************
	localparam ST_NORMAL = 3'd0;
	localparam ST_SETUP  = 3'd1;
	localparam ST_CBR    = 3'd2;
	localparam ST_PRE    = 3'd3;
	localparam ST_SELF   = 3'd4;
	localparam ST_WAIT   = 3'd5;
	localparam ST_NMI2   = 3'd6;

	reg [2:0]    state_ff;
	reg [2:0]    nxt_state;
	reg [TW-1:0] ph_ff;
	reg [TW-1:0] nxt_ph;
	reg [TW-1:0] osc_ff;
	reg [TW-1:0] nxt_osc;
	reg [3:0]    nmi_cnt_ff;
	reg [3:0]    nxt_nmi_cnt;
	reg          nxt_ras_n;
	reg          nxt_cas_n;
	reg          nxt_we_n;
	reg          nxt_srq_n;
	reg          nxt_grant;
	reg          nxt_nmi;
	reg          nxt_tinit;
	reg          nxt_cpu_rst;
	reg          ld_ref;
	reg          ld_gap;
	reg          ld_dly;
	wire         ref_due;
	wire         gap_due;
	wire         dly_done;

	// ****************************************
	// Timers
	// ****************************************
	// Average spacing of column-first refreshes
	sfr_timer #(.WIDTH(TW)) u_ref_tmr (
		.clk   (CLK),
		.rst_b (RST_B),
		.load  (ld_ref),
		.value (REFRESH_CYC[TW-1:0]),
		.done  (ref_due)
	);
	// Worst-case gap since the last refresh edge of either kind
	sfr_timer #(.WIDTH(TW)) u_gap_tmr (
		.clk   (CLK),
		.rst_b (RST_B),
		.load  (ld_gap),
		.value (RCF_MAX_CYC[TW-1:0] - `SFR_GAP_MARGIN_CYC), // [R10]
		.done  (gap_due)
	);
	// Power-return settle delay
	sfr_timer #(.WIDTH(TW)) u_dly_tmr (
		.clk   (CLK),
		.rst_b (RST_B),
		.load  (ld_dly),
		.value (RESUME_DLY_CYC[TW-1:0]),
		.done  (dly_done)
	);

	// ****************************************
	// Next-state logic
	// ****************************************
	always @* begin
		nxt_state   = state_ff;
		nxt_ph      = ph_ff;
		nxt_osc     = osc_ff;
		nxt_nmi_cnt = nmi_cnt_ff;
		nxt_ras_n   = RAS_N;
		nxt_cas_n   = CAS_N;
		nxt_we_n    = 1'b1;
		nxt_srq_n   = SELF_REFRESH_REQUEST_N;
		nxt_grant   = 1'b0;
		nxt_nmi     = NMI;
		nxt_tinit   = TIMING_INIT;
		nxt_cpu_rst = CPU_RESET_NMI;
		ld_ref      = 1'b0;
		ld_gap      = 1'b0;
		ld_dly      = 1'b0;
		if (nmi_cnt_ff != 4'h0) begin
			nxt_nmi_cnt = nmi_cnt_ff - 4'h1;
		end else begin
			nxt_cpu_rst = 1'b0;
		end
		case (state_ff)
			ST_NORMAL: begin
				if (pf_s) begin
					// Power fail: both lines raised, request low at once
					nxt_nmi   = 1'b1; // [R13]
					nxt_tinit = 1'b1; // [R14]
					nxt_srq_n = 1'b0; // [R13]
					nxt_ras_n = 1'b1;
					nxt_cas_n = 1'b1;
					nxt_osc   = 16'h0000;
					nxt_state = ST_SELF; // [R6]
				end else if (ref_due || gap_due) begin
					// Refresh preempts access; also bounds any access burst
					nxt_ras_n = 1'b1; // [R2]
					nxt_cas_n = 1'b0; // [R22] [R11]
					nxt_ph    = `SFR_CBR_SETUP_CYC;
					nxt_state = ST_SETUP;
				end else if (acc_s) begin
					nxt_grant = 1'b1;
					nxt_ras_n = ACCESS_RAS_N;
					nxt_cas_n = ACCESS_CAS_N;
					nxt_we_n  = ACCESS_WE_N;
				end else begin
					nxt_ras_n = 1'b1;
					nxt_cas_n = 1'b1;
				end
			end
			ST_SETUP: begin
				// No address is driven: memory counter supplies the row
				if (ph_ff == 16'h0001) begin
					nxt_ras_n = 1'b0; // [R3] [R22]
					ld_ref    = 1'b1; // [R1]
					ld_gap    = 1'b1; // [R8] [R9]
					nxt_ph    = `SFR_CBR_LOW_CYC;
					nxt_state = ST_CBR;
				end else begin
					nxt_ph = ph_ff - 16'h0001;
				end
			end
			ST_CBR: begin
				if (ph_ff == 16'h0001) begin
					nxt_ras_n = 1'b1;
					nxt_cas_n = 1'b1;
					nxt_ph    = `SFR_CBR_PRE_CYC;
					nxt_state = ST_PRE;
				end else begin
					nxt_ph = ph_ff - 16'h0001;
				end
			end
			ST_PRE: begin
				if (ph_ff == 16'h0001) begin
					nxt_state = ST_NORMAL;
				end else begin
					nxt_ph = ph_ff - 16'h0001;
				end
			end
			ST_SELF, ST_WAIT: begin
				// Oscillator owns the row strobe; counter stepping by 19 is internal
				nxt_cas_n = 1'b1;
				if (osc_ff == 16'h0000) begin
					nxt_ras_n = 1'b0; // [R15] [R16] [R19]
					ld_gap    = 1'b1; // [R7] [R9]
					nxt_osc   = OSC_CYC[TW-1:0] - 16'h0001;
				end else begin
					nxt_osc = osc_ff - 16'h0001;
					if (osc_ff == OSC_CYC[TW-1:0] - `SFR_OSC_LOW_CYC) begin
						nxt_ras_n = 1'b1;
					end
				end
				if (state_ff == ST_SELF) begin
					if (!pf_s) begin
						ld_dly    = 1'b1;
						nxt_state = ST_WAIT;
					end
				end else if (pf_s) begin
					nxt_state = ST_SELF;
				end else if (dly_done) begin
					// Second interrupt resets the processor first
					nxt_cpu_rst = 1'b1; // [R17]
					// Pulse drops on the edge after the count reaches zero
					nxt_nmi_cnt = `SFR_NMI_PULSE_CYC - 4'h1;
					nxt_state   = ST_NMI2;
				end
			end
			ST_NMI2: begin
				// Wait for the strobe high before handing back
				if (nmi_cnt_ff == 4'h0 && RAS_N && osc_ff != 16'h0000) begin
					nxt_srq_n = 1'b1; // [R17]
					nxt_nmi   = 1'b0;
					nxt_tinit = 1'b0;
					nxt_cas_n = 1'b1;
					nxt_state = ST_NORMAL;
					// First column-first cycle follows promptly after the last pulse
					nxt_ph    = `SFR_CBR_SETUP_CYC;
					nxt_cas_n = 1'b0; // [R8] [R12]
					nxt_state = ST_SETUP;
				end else begin
					nxt_osc = (osc_ff == 16'h0000) ? 16'h0001 : osc_ff - 16'h0001;
					if (osc_ff == OSC_CYC[TW-1:0] - `SFR_OSC_LOW_CYC) begin
						nxt_ras_n = 1'b1;
					end
				end
			end
			default: begin
				nxt_state = ST_NORMAL;
				nxt_ras_n = 1'b1;
				nxt_cas_n = 1'b1;
			end
		endcase
	end

	// ****************************************
	// Registers
	// ****************************************
	always @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			state_ff               <= ST_NORMAL;
			ph_ff                  <= 16'h0000;
			osc_ff                 <= 16'h0000;
			nmi_cnt_ff             <= 4'h0;
			RAS_N                  <= 1'b1;
			CAS_N                  <= 1'b1;
			WE_N                   <= 1'b1;
			SELF_REFRESH_REQUEST_N <= 1'b1;
			ACCESS_GRANT           <= 1'b0;
			NMI                    <= 1'b0;
			TIMING_INIT            <= 1'b0;
			CPU_RESET_NMI          <= 1'b0;
		end else begin
			state_ff               <= nxt_state;
			ph_ff                  <= nxt_ph;
			osc_ff                 <= nxt_osc;
			nmi_cnt_ff             <= nxt_nmi_cnt;
			RAS_N                  <= nxt_ras_n;
			CAS_N                  <= nxt_cas_n;
			WE_N                   <= nxt_we_n; // [R22]
			SELF_REFRESH_REQUEST_N <= nxt_srq_n;
			ACCESS_GRANT           <= nxt_grant;
			NMI                    <= nxt_nmi;
			TIMING_INIT            <= nxt_tinit;
			CPU_RESET_NMI          <= nxt_cpu_rst;
		end
	end
endmodule // sfr_ctrl
`default_nettype wire

// ### verif/sfr_mem_model.sv
// Refresh counter model of the pulse-refreshed memory.
// Assumes its strobes come straight from the controller.
`timescale 1ns/1ps
`default_nettype none
module sfr_mem_model (
	// Strobes
	input  wire logic       ras_n,
	input  wire logic       cas_n,
	input  wire logic       we_n,
	input  wire logic       self_refresh_request_n,
	// Observation
	output var  logic [8:0] row_cnt
);
	logic [4:0] div_ff;
	initial begin
		row_cnt = 9'h0;
		div_ff  = 5'h0;
	end
	// No data path, so no checking
	// Low-power entry delay after request is internal, not visible
	always @(negedge self_refresh_request_n) div_ff = 5'h0;
	always @(negedge ras_n) begin
		if (!self_refresh_request_n) begin
			div_ff = (div_ff == 5'h12) ? 5'h0 : div_ff + 5'h1;
			if (div_ff == 5'h0)
				row_cnt = row_cnt + 9'h1;
		end else if (!cas_n && we_n)
			row_cnt = row_cnt + 9'h1;
		// Row-only cycles leave the counter alone
	end
endmodule // sfr_mem_model
`default_nettype wire

// ### verif/sfr_ctrl_chk.sv
// Assertions on the refresh and power-fail controller ports.
// Assumes it is bound to sfr_ctrl with the same timer parameters.
`timescale 1ns/1ps
`default_nettype none
module sfr_ctrl_chk #(
	parameter RCF_MAX_CYC = 200,
	parameter OSC_CYC     = 800
) (
	// Clock and reset
	input wire logic CLK,
	input wire logic RST_B,
	// Watched signals
	input wire logic POWER_FAIL,
	input wire logic ACCESS_GRANT,
	input wire logic RAS_N,
	input wire logic CAS_N,
	input wire logic SELF_REFRESH_REQUEST_N,
	input wire logic NMI,
	input wire logic TIMING_INIT,
	input wire logic CPU_RESET_NMI
);
	logic [15:0] gap_ff;
	logic        sr_prev_ff;
	logic        ras_q_ff;
	logic        ref_fall;
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_B);
	// Access falls do not count: only refresh keeps rows alive
	// Own edge register: clock of a sampled function is unclear with two events
	assign ref_fall = ras_q_ff && !RAS_N && !ACCESS_GRANT;
	always @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			gap_ff     <= 16'h0;
			sr_prev_ff <= 1'b0;
			ras_q_ff   <= 1'b1;
		end else begin
			ras_q_ff <= RAS_N;
			if (ref_fall) begin
				gap_ff     <= 16'h1;
				sr_prev_ff <= !SELF_REFRESH_REQUEST_N;
			end else begin
				gap_ff     <= (gap_ff == 16'hffff) ? gap_ff : gap_ff + 16'h1;
				sr_prev_ff <= sr_prev_ff & !SELF_REFRESH_REQUEST_N;
			end
		end
	end
	sequence s_cbr_walk;
		(!CAS_N && RAS_N) [*2] ##1 (!RAS_N && !CAS_N) [*8] ##1 (RAS_N && CAS_N);
	endsequence
	sequence s_nmi2;
		CPU_RESET_NMI [*4] ##1 !CPU_RESET_NMI;
	endsequence
	a_cbr_walk: assert property ($fell(CAS_N) && RAS_N && !ACCESS_GRANT |-> s_cbr_walk)
		else $error("refresh walk broken");
	a_gap_normal: assert property (SELF_REFRESH_REQUEST_N |-> gap_ff <= RCF_MAX_CYC)
		else $error("refresh gap too long");
	a_sr_entry: assert property ($fell(RAS_N) && !SELF_REFRESH_REQUEST_N && !sr_prev_ff |-> gap_ff <= RCF_MAX_CYC)
		else $error("entry gap too long");
	a_sr_period: assert property ($fell(RAS_N) && !SELF_REFRESH_REQUEST_N && sr_prev_ff |-> gap_ff == OSC_CYC)
		else $error("oscillator period wrong");
	a_sr_low: assert property ($fell(RAS_N) && !SELF_REFRESH_REQUEST_N |-> (!RAS_N) [*8] ##1 RAS_N)
		else $error("oscillator pulse width wrong");
	a_pf_entry: assert property ($rose(POWER_FAIL) |-> ##[1:24] (NMI && !SELF_REFRESH_REQUEST_N))
		else $error("power fail not answered");
	a_init_pair: assert property (NMI == TIMING_INIT)
		else $error("init line differs from interrupt");
	a_nmi2_pulse: assert property ($rose(CPU_RESET_NMI) |-> s_nmi2 ##[0:12] $rose(SELF_REFRESH_REQUEST_N))
		else $error("second interrupt sequence wrong");
	a_release: assert property ($rose(SELF_REFRESH_REQUEST_N) |-> !NMI && !CAS_N && !CPU_RESET_NMI)
		else $error("release order wrong");
endmodule // sfr_ctrl_chk
bind sfr_ctrl sfr_ctrl_chk #(.RCF_MAX_CYC(RCF_MAX_CYC), .OSC_CYC(OSC_CYC)) u_chk (
	.CLK(CLK), .RST_B(RST_B), .POWER_FAIL(POWER_FAIL), .ACCESS_GRANT(ACCESS_GRANT),
	.RAS_N(RAS_N), .CAS_N(CAS_N), .SELF_REFRESH_REQUEST_N(SELF_REFRESH_REQUEST_N),
	.NMI(NMI), .TIMING_INIT(TIMING_INIT), .CPU_RESET_NMI(CPU_RESET_NMI));
`default_nettype wire

// ### verif/tb_top.sv
// Self-checking bench for the refresh and power-fail controller.
// Assumes shortened timers; every expectation derives from them.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	localparam RCF = 60;
	localparam OSC = 40;
	logic       clk = 0;
	logic       rst_b = 0;
	logic       power_fail = 0;
	logic       access_req = 0;
	logic       acc_ras_n = 1;
	logic       acc_cas_n = 1;
	logic       acc_we_n = 1;
	wire        grant, ras_n, cas_n, we_n, sr_req_n, nmi, timing_init, cpu_reset_nmi;
	wire  [8:0] row;
	int         failures = 0;
	int         check_count = 0;
	int         sr_pulses = 0;
	int         nmi2_n = 0;
	always #12.5 clk = ~clk;
	always @(negedge ras_n) if (!sr_req_n) sr_pulses++;
	always @(posedge cpu_reset_nmi) nmi2_n++;
	sfr_ctrl #(.REFRESH_CYC(50), .RCF_MAX_CYC(RCF), .OSC_CYC(OSC), .RESUME_DLY_CYC(20)) u_dut (
		.CLK(clk), .RST_B(rst_b), .POWER_FAIL(power_fail), .ACCESS_REQ(access_req),
		.ACCESS_RAS_N(acc_ras_n), .ACCESS_CAS_N(acc_cas_n), .ACCESS_WE_N(acc_we_n), .ACCESS_GRANT(grant),
		.RAS_N(ras_n), .CAS_N(cas_n), .WE_N(we_n), .SELF_REFRESH_REQUEST_N(sr_req_n),
		.NMI(nmi), .TIMING_INIT(timing_init), .CPU_RESET_NMI(cpu_reset_nmi));
	sfr_mem_model u_mem (.ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .self_refresh_request_n(sr_req_n), .row_cnt(row));
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic finish_test();
		$display("checks %0d mismatches %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// Inputs change only at the falling edge
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic t_reset();
		cyc(8);
		chk({8'h0, ras_n, cas_n, we_n, sr_req_n, nmi, timing_init, cpu_reset_nmi, grant}, 16'hf0);
		rst_b = 1;
		cyc(4);
		chk({7'h0, row}, 16'h1);
	endtask
	task automatic t_access();
		logic [8:0] r0;
		access_req = 1;
		for (int i = 0; i < 30 && grant !== 1'b1; i++) cyc(1);
		chk({15'h0, grant}, 16'h1);
		// Write access: grant held, row strobe and write enable passed through low
		acc_ras_n = 0;
		acc_we_n = 0;
		cyc(2);
		chk({13'h0, grant, ras_n, we_n}, 16'h4);
		r0 = row;
		cyc(6 * RCF);
		// Long access must not starve refresh
		chk({15'h0, (row - r0) >= 9'h5}, 16'h1);
		acc_ras_n = 1;
		acc_we_n = 1;
		access_req = 0;
		cyc(4);
	endtask
	task automatic t_power_fail();
		logic [8:0] r0;
		int p0;
		power_fail = 1;
		for (int i = 0; i < 30 && nmi !== 1'b1; i++) cyc(1);
		chk({14'h0, sr_req_n, timing_init}, 16'h1);
		cyc(OSC);
		p0 = sr_pulses;
		r0 = row;
		cyc(19 * OSC);
		chk(16'(sr_pulses - p0), 16'h13);
		chk({7'h0, row - r0}, 16'h1);
		chk({15'h0, grant}, 16'h0);
	endtask
	// Short dip inside the resume delay must not hand back
	task automatic t_fail_again();
		power_fail = 0;
		cyc(8);
		power_fail = 1;
		cyc(60);
		chk({sr_req_n, 15'(nmi2_n)}, 16'h0);
	endtask
	task automatic t_power_return();
		logic [8:0] r0;
		power_fail = 0;
		for (int i = 0; i < 60 && cpu_reset_nmi !== 1'b1; i++) cyc(1);
		chk({14'h0, nmi, sr_req_n}, 16'h2);
		for (int i = 0; i < 20 && sr_req_n !== 1'b1; i++) cyc(1);
		r0 = row;
		chk({14'h0, nmi, cas_n}, 16'h0);
		cyc(3);
		chk({7'h0, row - r0}, 16'h1);
		chk(16'(nmi2_n), 16'h1);
	endtask
	initial begin
		t_reset();
		t_access();
		t_power_fail();
		t_fail_again();
		t_power_return();
		finish_test();
	end
	initial begin
		repeat (5000) @(posedge clk);
		failures++;
		finish_test();
	end
endmodule // tb_top
`default_nettype wire
